/* core/ffsup_pkg.sv */
// package of constants and types for the feed fault supervisor
package ffsup_pkg;
	localparam int CLK_HZ = 250000000;
	localparam int MOTION_TIMEOUT_MS = 1000;
	localparam int MOTION_TIMEOUT_CYC = (CLK_HZ / 1000) * MOTION_TIMEOUT_MS;
	localparam int FLASH_BLINK_MS = 250;
	localparam int FLASH_BLINK_CYC = (CLK_HZ / 1000) * FLASH_BLINK_MS;
	localparam int PRESS_TMR_W = 32;
	localparam int ERR_CODE_W = 9;
	localparam int EXC_W = 3;
	localparam logic [ERR_CODE_W-1:0] ERR_NONE = 9'h000;
	localparam logic [ERR_CODE_W-1:0] ERR_BUS = 9'h002;
	localparam logic [ERR_CODE_W-1:0] ERR_ADDR = 9'h003;
	localparam logic [ERR_CODE_W-1:0] ERR_ILLEGAL = 9'h004;
	localparam logic [ERR_CODE_W-1:0] ERR_DIVZERO = 9'h005;
	localparam logic [ERR_CODE_W-1:0] ERR_PRIV = 9'h008;
	localparam logic [ERR_CODE_W-1:0] ERR_SPURIOUS = 9'h018;
	localparam logic [ERR_CODE_W-1:0] ERR_KEY_STUCK = 9'h12d;
	localparam logic [ERR_CODE_W-1:0] ERR_KEY_REV = 9'h12e;
	localparam logic [ERR_CODE_W-1:0] ERR_BOARD_REV = 9'h12f;
	localparam logic [ERR_CODE_W-1:0] ERR_POWER = 9'h130;
	localparam logic [ERR_CODE_W-1:0] ERR_SERIAL = 9'h131;
	localparam logic [ERR_CODE_W-1:0] ERR_FLASH_WEAR = 9'h137;
	// exception cause encoding on exc_cause_in
	localparam logic [EXC_W-1:0] EXC_BUS = 3'h0;
	localparam logic [EXC_W-1:0] EXC_ADDR = 3'h1;
	localparam logic [EXC_W-1:0] EXC_ILLEGAL = 3'h2;
	localparam logic [EXC_W-1:0] EXC_DIVZERO = 3'h3;
	localparam logic [EXC_W-1:0] EXC_PRIV = 3'h4;
	localparam logic [EXC_W-1:0] EXC_SPURIOUS = 3'h5;
	typedef enum logic [1:0] {FFSUP_MODE_INIT, FFSUP_MODE_MANUAL, FFSUP_MODE_AUTO} ffsup_mode_t;
endpackage

/* core/ffsup_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module ffsup_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stage;
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta <= '0;
			stage <= '0;
		end else begin
			meta <= async_in;
			stage <= meta;
		end
	end
	assign sync_out = stage;
endmodule // ffsup_sync

/* core/ffsup_timer.sv */
// restartable down-counter that flags expiry of a programmed interval
`timescale 1ns/10ps
module ffsup_timer #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// control
	input wire logic run_in,
	input wire logic restart_in,
	input wire logic [WIDTH-1:0] limit_in,
	// status
	output logic expired_out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_expired;
	always_comb begin
		next_count = count;
		next_expired = 1'b0;
		if (!run_in || restart_in) begin
			next_count = limit_in;
		end else if (count != '0) begin
			next_count = count - 1'b1;
			next_expired = (count == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count <= '0;
			expired_out <= 1'b0;
		end else begin
			count <= next_count;
			expired_out <= next_expired;
		end
	end
endmodule // ffsup_timer

/* core/ffsup_top.sv */
// feed fault supervisor: drive fault polling, hard and soft faults, error codes
// Behaviour
// - poll drive fault status continuously while operating
// - any drive error lights clear, flashes status
// - hard fault: init mode, outputs low, stop
// - hold enable until in-motion low, then drop
// - faults stay pending until clear key press
// - feed angle falls in motion or jog: hard
// - drive fault is hard fault, detail shown
// - soft fault stops cycle, keeps enable, mode
// - no feed angle edge in interval: soft
// - no in-motion one second after start: soft
// - enable not seen at drive: disabled warning
// - drive not ready: not-ready warning
// - exceptions report codes 2,3,4,5,8,24
// - stuck key at self-test reports 301
// - bad keypad rev 302, board rev 303
// - undervoltage power fail reports 304
// - serial port self-test failure reports 305
// - flash write limit exceeded reports 311
`timescale 1ns/10ps
module ffsup_top
	import ffsup_pkg::*;
#(
	parameter int MOTION_CYC = ffsup_pkg::MOTION_TIMEOUT_CYC,
	parameter int BLINK_CYC = ffsup_pkg::FLASH_BLINK_CYC,
	parameter int DETAIL_W = 16
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// drive pins (asynchronous)
	input wire logic drive_fault_in,
	input wire logic [DETAIL_W-1:0] drive_detail_in,
	input wire logic drive_in_motion_in,
	input wire logic drive_enable_seen_in,
	input wire logic drive_ready_state_in,
	// press pin (asynchronous)
	input wire logic feed_angle_in,
	// operator keys (asynchronous)
	input wire logic clear_key_in,
	// controller status from the sequencing logic (same clock)
	input wire logic auto_mode_in,
	input wire logic jogging_in,
	input wire logic cycle_start_in,
	input wire logic cycling_in,
	input wire logic init_done_in,
	input wire logic [ffsup_pkg::PRESS_TMR_W-1:0] press_interval_in,
	// self-test and processor events (same clock)
	input wire logic exc_valid_in,
	input wire logic [ffsup_pkg::EXC_W-1:0] exc_cause_in,
	input wire logic selftest_active_in,
	input wire logic key_stuck_in,
	input wire logic keypad_rev_bad_in,
	input wire logic board_rev_bad_in,
	input wire logic serial_test_fail_in,
	input wire logic power_fail_in,
	input wire logic flash_wear_in,
	// drive outputs
	output logic drive_enable_line_out,
	output logic cycle_stop_out,
	output logic outputs_off_out,
	// mode and indicators
	output ffsup_pkg::ffsup_mode_t mode_out,
	output logic clear_led_out,
	output logic drive_status_key_led_out,
	// fault and warning status
	output logic hard_fault_out,
	output logic soft_fault_out,
	output logic feed_angle_lost_out,
	output logic drive_error_out,
	output logic press_timeout_out,
	output logic motion_timeout_out,
	output logic drive_disabled_warn_out,
	output logic drive_not_ready_warn_out,
	output logic [DETAIL_W-1:0] drive_detail_out,
	output logic [ffsup_pkg::ERR_CODE_W-1:0] error_code_out
);
	import ffsup_pkg::*;

	localparam int NPIN = 5;
	logic [NPIN-1:0] pins_raw;
	logic [NPIN-1:0] pins_sync;
	logic fault_s, motion_s, en_seen_s, ready_s, angle_s;
	logic [DETAIL_W-1:0] detail_s1, detail_s2;
	logic [1:0] clear_sync;
	logic clear_prev;
	logic clear_press;
	logic angle_prev;
	logic angle_fall;
	logic angle_edge;
	logic press_expired;

	assign pins_raw = {drive_fault_in, drive_in_motion_in, drive_enable_seen_in,
		drive_ready_state_in, feed_angle_in};
	// drive status is sampled every cycle, so polling never pauses
	ffsup_sync #(.WIDTH(NPIN)) u_pin_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);
	assign {fault_s, motion_s, en_seen_s, ready_s, angle_s} = pins_sync;

	// fault flags and handling state
	logic flag_angle, flag_drive, flag_press, flag_motion;
	logic next_flag_angle, next_flag_drive, next_flag_press, next_flag_motion;
	logic hard_pending, soft_pending;
	ffsup_mode_t mode, next_mode;
	logic enable, next_enable;
	logic [31:0] motion_cnt, next_motion_cnt;
	logic motion_wait, next_motion_wait;
	logic [31:0] blink_cnt, next_blink_cnt;
	logic blink, next_blink;
	logic [DETAIL_W-1:0] detail, next_detail;
	logic [ERR_CODE_W-1:0] err_code, next_err_code;
	logic motion_expired;

	// the feed angle sync resets low, so a release shows a rise, never a loss
	assign angle_fall = angle_prev & ~angle_s;
	assign angle_edge = angle_prev ^ angle_s;
	assign clear_press = clear_sync[1] & ~clear_prev;
	assign hard_pending = flag_angle | flag_drive;
	assign soft_pending = flag_press | flag_motion;
	assign motion_expired = motion_wait && (motion_cnt == 32'h0000_0001);

	// press interval restarts on every feed angle edge
	ffsup_timer #(.WIDTH(PRESS_TMR_W)) u_press_tmr (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.run_in(auto_mode_in & cycling_in & (mode == FFSUP_MODE_AUTO)),
		.restart_in(angle_edge),
		.limit_in(press_interval_in),
		.expired_out(press_expired)
	);

	always_comb begin
		next_flag_angle = flag_angle;
		next_flag_drive = flag_drive;
		next_flag_press = flag_press;
		next_flag_motion = flag_motion;
		// a clear press removes pending faults; a same-cycle event still sets
		if (clear_press) begin
			next_flag_angle = 1'b0;
			next_flag_drive = 1'b0;
			next_flag_press = 1'b0;
			next_flag_motion = 1'b0;
		end
		if (angle_fall && (motion_s || jogging_in)) begin
			next_flag_angle = 1'b1;
		end
		if (fault_s) begin
			next_flag_drive = 1'b1;
		end
		if (press_expired) begin
			next_flag_press = 1'b1;
		end
		if (motion_expired) begin
			next_flag_motion = 1'b1;
		end
	end

	always_comb begin
		next_mode = mode;
		next_enable = enable;
		next_motion_cnt = motion_cnt;
		next_motion_wait = motion_wait;
		next_detail = detail;
		if (fault_s) begin
			next_detail = detail_s2;
		end
		// motion timeout watch starts at cycle start, ends on in-motion
		if (cycle_start_in) begin
			next_motion_wait = 1'b1;
			next_motion_cnt = MOTION_CYC[31:0];
		end else if (motion_s || motion_expired || !cycling_in) begin
			next_motion_wait = 1'b0;
		end else if (motion_wait) begin
			next_motion_cnt = motion_cnt - 32'h0000_0001;
		end
		unique case (mode)
			FFSUP_MODE_INIT: begin
				// enable held through a stop until the axis stops moving
				if (hard_pending || next_flag_angle || next_flag_drive) begin
					if (!motion_s) begin
						next_enable = 1'b0;
					end
				end else if (init_done_in && ready_s) begin
					next_enable = 1'b1;
					next_mode = FFSUP_MODE_MANUAL;
				end
			end
			FFSUP_MODE_MANUAL, FFSUP_MODE_AUTO: begin
				// hard wins over soft: it already carries the cycle stop
				if (next_flag_angle || next_flag_drive) begin
					next_mode = FFSUP_MODE_INIT;
					next_enable = motion_s;
				end else begin
					next_mode = auto_mode_in ? FFSUP_MODE_AUTO : FFSUP_MODE_MANUAL;
				end
			end
			default: begin
				next_mode = FFSUP_MODE_INIT;
				next_enable = 1'b0;
			end
		endcase
	end

	// blinking of the drive status key while a fault is pending
	always_comb begin
		next_blink_cnt = blink_cnt;
		next_blink = blink;
		if (!hard_pending && !soft_pending) begin
			next_blink_cnt = 32'h0;
			next_blink = 1'b0;
		end else if (blink_cnt >= BLINK_CYC[31:0] - 32'h1) begin
			next_blink_cnt = 32'h0;
			next_blink = ~blink;
		end else begin
			next_blink_cnt = blink_cnt + 32'h1;
		end
	end

	// last reported firmware error code; later events overwrite it
	always_comb begin
		next_err_code = err_code;
		if (exc_valid_in) begin
			unique case (exc_cause_in)
				EXC_BUS: next_err_code = ERR_BUS;
				EXC_ADDR: next_err_code = ERR_ADDR;
				EXC_ILLEGAL: next_err_code = ERR_ILLEGAL;
				EXC_DIVZERO: next_err_code = ERR_DIVZERO;
				EXC_PRIV: next_err_code = ERR_PRIV;
				EXC_SPURIOUS: next_err_code = ERR_SPURIOUS;
				default: next_err_code = ERR_SPURIOUS;
			endcase
		end else if (power_fail_in) begin
			next_err_code = ERR_POWER;
		end else if (flash_wear_in) begin
			next_err_code = ERR_FLASH_WEAR;
		end else if (selftest_active_in) begin
			if (key_stuck_in) begin
				next_err_code = ERR_KEY_STUCK;
			end else if (keypad_rev_bad_in) begin
				next_err_code = ERR_KEY_REV;
			end else if (board_rev_bad_in) begin
				next_err_code = ERR_BOARD_REV;
			end else if (serial_test_fail_in) begin
				next_err_code = ERR_SERIAL;
			end
		end
	end

	// pin-side sampling; clear key and feed angle keep a previous copy
	// so that one press or one edge is acted on only once
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			detail_s1 <= '0;
			detail_s2 <= '0;
			clear_sync <= 2'b00;
			clear_prev <= 1'b0;
			angle_prev <= 1'b0;
		end else begin
			detail_s1 <= drive_detail_in;
			detail_s2 <= detail_s1;
			clear_sync <= {clear_sync[0], clear_key_in};
			clear_prev <= clear_sync[1];
			angle_prev <= angle_s;
		end
	end

	// fault flags
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			flag_angle <= 1'b0;
			flag_drive <= 1'b0;
			flag_press <= 1'b0;
			flag_motion <= 1'b0;
		end else begin
			flag_angle <= next_flag_angle;
			flag_drive <= next_flag_drive;
			flag_press <= next_flag_press;
			flag_motion <= next_flag_motion;
		end
	end

	// mode, enable, motion watch and captured detail
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode <= FFSUP_MODE_INIT;
			enable <= 1'b0;
			motion_cnt <= 32'h0;
			motion_wait <= 1'b0;
			detail <= '0;
		end else begin
			mode <= next_mode;
			enable <= next_enable;
			motion_cnt <= next_motion_cnt;
			motion_wait <= next_motion_wait;
			detail <= next_detail;
		end
	end

	// status key blink state
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			blink_cnt <= 32'h0;
			blink <= 1'b0;
		end else begin
			blink_cnt <= next_blink_cnt;
			blink <= next_blink;
		end
	end

	// error code; a clear press leaves it alone, only reset returns it
	// to none, so the last cause stays readable after recovery
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			err_code <= ERR_NONE;
		end else begin
			err_code <= next_err_code;
		end
	end

	assign drive_enable_line_out = enable;
	assign mode_out = mode;
	// any pending fault orders a cycle stop; only hard drops the outputs
	assign cycle_stop_out = hard_pending | soft_pending;
	assign outputs_off_out = (mode == FFSUP_MODE_INIT);
	assign clear_led_out = hard_pending | soft_pending;
	assign drive_status_key_led_out = blink;
	assign hard_fault_out = hard_pending;
	assign soft_fault_out = soft_pending;
	assign feed_angle_lost_out = flag_angle;
	assign drive_error_out = flag_drive;
	assign press_timeout_out = flag_press;
	assign motion_timeout_out = flag_motion;
	assign drive_disabled_warn_out = enable & ~en_seen_s;
	// the ready sync resets low, so the warning shows from reset on
	assign drive_not_ready_warn_out = ~ready_s;
	assign drive_detail_out = detail;
	assign error_code_out = err_code;
endmodule // ffsup_top

/* test/ffsup_top_properties.sv */
// port-level checker for the feed fault supervisor
`timescale 1ns/10ps
module ffsup_chk
	import ffsup_pkg::*;
#(
	parameter int MOTION_CYC = 50,
	parameter int BLINK_CYC = 4
) (
	// clock, reset and inputs
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic drive_in_motion_in,
	input wire logic drive_enable_seen_in,
	input wire logic drive_ready_state_in,
	input wire logic clear_key_in,
	input wire logic exc_valid_in,
	input wire logic [ffsup_pkg::EXC_W-1:0] exc_cause_in,
	input wire logic power_fail_in,
	// outputs
	input wire logic drive_enable_line_out,
	input wire logic cycle_stop_out,
	input wire logic outputs_off_out,
	input wire ffsup_pkg::ffsup_mode_t mode_out,
	input wire logic clear_led_out,
	input wire logic hard_fault_out,
	input wire logic soft_fault_out,
	input wire logic feed_angle_lost_out,
	input wire logic drive_error_out,
	input wire logic press_timeout_out,
	input wire logic motion_timeout_out,
	input wire logic drive_disabled_warn_out,
	input wire logic drive_not_ready_warn_out,
	input wire logic [ffsup_pkg::ERR_CODE_W-1:0] error_code_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	hard_init_a: assert property (hard_fault_out |-> mode_out == FFSUP_MODE_INIT
		&& outputs_off_out) else $error("hard fault outside init");
	stop_pend_a: assert property ((hard_fault_out || soft_fault_out) |-> cycle_stop_out
		&& clear_led_out) else $error("pending fault without stop");
	hard_kind_a: assert property ((drive_error_out || feed_angle_lost_out) |-> hard_fault_out)
		else $error("hard kind not hard");
	soft_kind_a: assert property ((press_timeout_out || motion_timeout_out) |-> soft_fault_out)
		else $error("soft kind not soft");
	enable_hold_a: assert property ($fell(drive_enable_line_out) && hard_fault_out
		|-> !$past(drive_in_motion_in, 3)) else $error("enable dropped in motion");
	enable_keep_a: assert property (soft_fault_out && !hard_fault_out ##1 !hard_fault_out
		|-> $stable(drive_enable_line_out)) else $error("soft fault moved enable");
	clear_gate_a: assert property (($fell(hard_fault_out) || $fell(soft_fault_out))
		|-> $past(clear_key_in, 3)) else $error("fault gone without clear");
	spur_code_a: assert property (exc_valid_in && exc_cause_in == EXC_SPURIOUS
		|=> error_code_out == ERR_SPURIOUS) else $error("spurious code wrong");
	power_code_a: assert property (power_fail_in && !exc_valid_in
		|=> error_code_out == ERR_POWER) else $error("power code wrong");
	not_ready_a: assert property (!$past(sys_rst_in, 3) |-> drive_not_ready_warn_out
		== !$past(drive_ready_state_in, 2)) else $error("not-ready warning wrong");
	disabled_a: assert property (!$past(sys_rst_in, 3) |-> drive_disabled_warn_out
		== (drive_enable_line_out && !$past(drive_enable_seen_in, 2))) else $error("disabled warn");
	cover property (hard_fault_out && soft_fault_out);
	cover property ($fell(drive_enable_line_out) && hard_fault_out);
	cover property (motion_timeout_out && drive_enable_line_out);
endmodule // ffsup_chk
bind ffsup_top ffsup_chk #(.MOTION_CYC(MOTION_CYC), .BLINK_CYC(BLINK_CYC)) chk (.*);

/* test/ffsup_drive_model.sv */
// servo drive and press switch model facing the supervisor
`timescale 1ns/10ps
module ffsup_drive_model #(
	parameter logic [3:0] LAG = 4'h3
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// bench commands
	input wire logic move_in,
	input wire logic fault_in,
	input wire logic ready_in,
	input wire logic wire_ok_in,
	input wire logic press_up_in,
	input wire logic [15:0] detail_in,
	// drive side
	input wire logic drive_enable_line_in,
	output logic drive_fault_out,
	output logic [15:0] drive_detail_out,
	output logic drive_in_motion_out,
	output logic drive_enable_seen_out,
	output logic drive_ready_state_out,
	output logic feed_angle_out
);
	logic [3:0] lag_cnt;
	// the axis turns only while enabled, after a start lag
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lag_cnt <= 4'h0;
		end else if (move_in && drive_enable_line_in) begin
			lag_cnt <= (lag_cnt == LAG) ? lag_cnt : lag_cnt + 4'h1;
		end else begin
			lag_cnt <= 4'h0;
		end
	end
	assign drive_in_motion_out = (lag_cnt == LAG);
	assign drive_fault_out = fault_in;
	// detail is not valid without a fault, so it shows garbage then
	assign drive_detail_out = fault_in ? detail_in : ~detail_in;
	assign drive_enable_seen_out = drive_enable_line_in && wire_ok_in;
	assign drive_ready_state_out = ready_in;
	assign feed_angle_out = press_up_in;
endmodule // ffsup_drive_model

/* test/ffsup_top_test.sv */
// self-checking bench for the feed fault supervisor
`timescale 1ns/10ps
module ffsup_top_test;
	import ffsup_pkg::*;
	localparam int MCYC = 50;
	localparam int BCYC = 4;
	localparam logic [8:0] LVC [7] = '{ERR_KEY_STUCK, ERR_KEY_REV, ERR_BOARD_REV, ERR_SERIAL,
		ERR_FLASH_WEAR, ERR_POWER, ERR_POWER};
	localparam logic [8:0] XC [6] = '{ERR_BUS, ERR_ADDR, ERR_ILLEGAL, ERR_DIVZERO, ERR_PRIV,
		ERR_SPURIOUS};
	logic clk = 1'b0, rst = 1'b1, move = 1'b0, flt = 1'b0, rdy = 1'b0, wok = 1'b1, up = 1'b1;
	logic clr = 1'b0, auto = 1'b0, jog = 1'b0, start = 1'b0, cyc = 1'b0, idone = 1'b0;
	logic exv = 1'b0, st = 1'b0, s;
	logic [2:0] exc = 3'h0;
	logic [5:0] lv = 6'h0;
	logic [31:0] pint = 32'h3e8;
	logic fw, mw, sw, rw, aw, en, stop, off, cled, sled, hf, sf, fal, derr, pto, mto, dw, nw;
	logic [15:0] det_w, det_o;
	logic [8:0] code;
	logic [7:0] probe;
	ffsup_mode_t mode;
	int error_cnt = 0;
	int num_checks = 0;
	int w;
	initial forever #2 clk = ~clk;
	// probe bits: hf, en, fal, mto, pto, manual, auto, status led
	assign probe = {sled, mode == FFSUP_MODE_AUTO, mode == FFSUP_MODE_MANUAL, pto, mto, fal, en, hf};
	ffsup_drive_model pm (.ref_clk_in(clk), .sys_rst_in(rst), .move_in(move), .fault_in(flt),
		.ready_in(rdy), .wire_ok_in(wok), .press_up_in(up), .detail_in(16'h5a3c),
		.drive_enable_line_in(en), .drive_fault_out(fw), .drive_detail_out(det_w),
		.drive_in_motion_out(mw), .drive_enable_seen_out(sw), .drive_ready_state_out(rw),
		.feed_angle_out(aw));
	ffsup_top #(.MOTION_CYC(MCYC), .BLINK_CYC(BCYC), .DETAIL_W(16)) dut (.ref_clk_in(clk),
		.sys_rst_in(rst), .drive_fault_in(fw), .drive_detail_in(det_w), .drive_in_motion_in(mw),
		.drive_enable_seen_in(sw), .drive_ready_state_in(rw), .feed_angle_in(aw),
		.clear_key_in(clr), .auto_mode_in(auto), .jogging_in(jog), .cycle_start_in(start),
		.cycling_in(cyc), .init_done_in(idone), .press_interval_in(pint), .exc_valid_in(exv),
		.exc_cause_in(exc), .selftest_active_in(st), .key_stuck_in(lv[0]),
		.keypad_rev_bad_in(lv[1]), .board_rev_bad_in(lv[2]), .serial_test_fail_in(lv[3]),
		.flash_wear_in(lv[4]), .power_fail_in(lv[5]), .drive_enable_line_out(en),
		.cycle_stop_out(stop), .outputs_off_out(off), .mode_out(mode), .clear_led_out(cled),
		.drive_status_key_led_out(sled), .hard_fault_out(hf), .soft_fault_out(sf),
		.feed_angle_lost_out(fal), .drive_error_out(derr), .press_timeout_out(pto),
		.motion_timeout_out(mto), .drive_disabled_warn_out(dw), .drive_not_ready_warn_out(nw),
		.drive_detail_out(det_o), .error_code_out(code));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t value %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait on one probe bit; running out ends the run
	task automatic wait_for(input int b, input logic lvl, input int lim, output int n);
		for (n = 0; n < lim; n++) begin
			if (probe[b] === lvl) return;
			@(negedge clk);
		end
		error_cnt++;
		$display("BAD %0t wait ran out", $time);
		tally_and_finish();
	endtask
	// the key passes a two-flop synchroniser, so it is held two cycles
	task automatic press_clear;
		clr = 1'b1;
		cyc_n(2);
		clr = 1'b0;
		cyc_n(6);
	endtask
	task automatic bring_up;
		rdy = 1'b1;
		idone = 1'b1;
		wait_for(5, 1'b1, 30, w);
		wait_for(1, 1'b1, 10, w);
		cyc_n(3);
		check_bit(nw, 1'b0);
		wok = 1'b0;
		cyc_n(4);
		check_bit(dw, 1'b1);
		wok = 1'b1;
		cyc_n(4);
		check_bit(dw, 1'b0);
	endtask
	task automatic drive_fault;
		move = 1'b1;
		cyc_n(10);
		flt = 1'b1;
		wait_for(0, 1'b1, 10, w);
		check_bit(derr, 1'b1);
		check_val({14'h0, mode}, {14'h0, FFSUP_MODE_INIT});
		check_bit(off, 1'b1);
		check_bit(stop, 1'b1);
		check_bit(en, 1'b1);
		check_bit(cled, 1'b1);
		cyc_n(2);
		check_val(det_o, 16'h5a3c);
		s = sled;
		wait_for(7, !s, 2 * BCYC + 2, w);
		wait_for(7, s, BCYC + 2, w);
		check_bit(w == BCYC, 1'b1);
		move = 1'b0;
		wait_for(1, 1'b0, 10, w);
		check_bit(hf, 1'b1);
		press_clear();
		check_bit(hf, 1'b1);
		flt = 1'b0;
		cyc_n(4);
		press_clear();
		check_bit(derr, 1'b0);
		wait_for(5, 1'b1, 30, w);
	endtask
	task automatic angle_lost;
		jog = 1'b1;
		cyc_n(2);
		up = 1'b0;
		wait_for(2, 1'b1, 10, w);
		check_bit(hf, 1'b1);
		check_val({14'h0, mode}, {14'h0, FFSUP_MODE_INIT});
		up = 1'b1;
		jog = 1'b0;
		cyc_n(4);
		press_clear();
		check_bit(fal, 1'b0);
		wait_for(5, 1'b1, 30, w);
	endtask
	task automatic motion_late;
		auto = 1'b1;
		wait_for(6, 1'b1, 10, w);
		cyc = 1'b1;
		start = 1'b1;
		cyc_n(1);
		start = 1'b0;
		wait_for(3, 1'b1, MCYC + 10, w);
		check_bit(w >= MCYC - 3, 1'b1);
		check_bit(hf, 1'b0);
		check_bit(en, 1'b1);
		check_bit(stop, 1'b1);
		check_val({14'h0, mode}, {14'h0, FFSUP_MODE_AUTO});
		flt = 1'b1;
		wait_for(0, 1'b1, 10, w);
		check_val({14'h0, mode}, {14'h0, FFSUP_MODE_INIT});
		flt = 1'b0;
		cyc = 1'b0;
		auto = 1'b0;
		cyc_n(4);
		press_clear();
		check_bit(sf, 1'b0);
		wait_for(5, 1'b1, 30, w);
	endtask
	task automatic press_late;
		auto = 1'b1;
		pint = 32'h1e;
		wait_for(6, 1'b1, 10, w);
		cyc = 1'b1;
		repeat (4) begin
			cyc_n(15);
			up = ~up;
		end
		check_bit(pto, 1'b0);
		wait_for(4, 1'b1, 80, w);
		check_bit(w >= 25, 1'b1);
		check_bit(en, 1'b1);
		cyc = 1'b0;
		auto = 1'b0;
		press_clear();
		check_bit(pto, 1'b0);
	endtask
	task automatic codes;
		st = 1'b1;
		for (int i = 0; i < 7; i++) begin
			lv = (i < 6) ? 6'h1 << i : 6'h30;
			cyc_n(3);
			check_val({7'h0, code}, {7'h0, LVC[i]});
		end
		lv = 6'h0;
		st = 1'b0;
		// valid stays up across the causes, never dropped and raised at once
		exv = 1'b1;
		for (int i = 0; i < 6; i++) begin
			exc = 3'(i);
			cyc_n(1);
			check_val({7'h0, code}, {7'h0, XC[i]});
		end
		exv = 1'b0;
	endtask
	initial begin
		cyc_n(6);
		check_bit(en, 1'b0);
		check_bit(nw, 1'b1);
		rst = 1'b0;
		bring_up();
		drive_fault();
		angle_lost();
		motion_late();
		press_late();
		codes();
		tally_and_finish();
	end
endmodule // ffsup_top_test
